// >>> rtl/agco_observe.sv
// gain control state machine with state observe output
`timescale 1ns/1ps
module agco_observe
    import agco_pkg::*;
#(
    parameter int unsigned SENSE_DELAY = SENSE_DLY,
    parameter int unsigned FSYNC_DELAY = FS_DLY,
    parameter int unsigned FS_WAIT     = FS_WAIT_UNITS,
    parameter int unsigned UNIT_CYCLES = UNIT_CYC
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // configuration
    input  wire agco_cfg_t         cfg_i,
    input  wire logic              rx_mode_i,
    // receive events and conditions
    input  wire agco_sense_t       sense_i,
    input  wire logic              burst_start_i,
    input  wire logic              fsync_i,
    // manual gain step request
    input  wire logic              man_up_i,
    input  wire logic              man_down_i,
    // gain actions
    output logic                   gain_up_o,
    output logic                   gain_down_o,
    // observe output
    output logic [CODE_W-1:0]      obs_code_o,
    output logic                   obs_dac_wr_o,
    output logic                   obs_adc_wr_o,
    output logic [1:0]             obs_chan_o,
    output logic [AUX_N-1:0]       dac_held_o,
    output logic [AUX_N-1:0]       adc_held_o,
    output agco_state_t            state_o
);

    // delay lines for sensing and frame sync
    logic [SENSE_DELAY*3-1:0] sdl_r;
    logic [SENSE_DELAY*3-1:0] sdl_nxt;
    logic [FSYNC_DELAY-1:0]   fdl_r;
    logic [FSYNC_DELAY-1:0]   fdl_nxt;
    agco_sense_t              sense_d;
    logic                     fsync_d;

    always_comb begin
        sdl_nxt = {sdl_r[SENSE_DELAY*3-4:0], sense_i};
        fdl_nxt = {fdl_r[FSYNC_DELAY-2:0], fsync_i};
        sense_d = sdl_r[SENSE_DELAY*3-1 -: 3];
        fsync_d = fdl_r[FSYNC_DELAY-1];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sdl_r <= '0;
            fdl_r <= '0;
        end else begin
            sdl_r <= sdl_nxt;
            fdl_r <= fdl_nxt;
        end
    end

    // state machine and burst timer
    localparam int unsigned TW = $clog2(FS_WAIT + 1);

    agco_state_t   st_r;
    agco_state_t   st_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    logic          unit_tick;
    logic          auto_on;

    agco_unit_tick #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .clr_i  (st_r == AGCO_WAIT),
        .tick_o (unit_tick)
    );

    always_comb begin
        auto_on = rx_mode_i && (cfg_i.mode != AGCO_MODE_MANUAL);
        st_nxt  = st_r;
        tmr_nxt = tmr_r;
        if (!auto_on) begin
            st_nxt  = AGCO_WAIT;
            tmr_nxt = '0;
        end else begin
            case (st_r)
                AGCO_WAIT: begin
                    tmr_nxt = '0;
                    if (burst_start_i) begin
                        st_nxt = AGCO_BURST;
                    end
                end
                AGCO_BURST, AGCO_PRE_NOHI: begin
                    if (unit_tick) begin
                        tmr_nxt = tmr_r + 1'b1;
                    end
                    if (fsync_d) begin
                        tmr_nxt = '0;
                        case (cfg_i.mode)
                            AGCO_MODE_LOCK: st_nxt = AGCO_FS_LOCK;
                            AGCO_MODE_DOWN: st_nxt = AGCO_FS_DOWN;
                            default:        st_nxt = AGCO_FS_ANY;
                        endcase
                    end else if (tmr_r == TW'(FS_WAIT)) begin
                        st_nxt = AGCO_WAIT;
                    end else if (st_r == AGCO_BURST && cfg_i.no_high) begin
                        st_nxt = AGCO_PRE_NOHI;
                    end
                end
                default: begin
                    // stays until receive or auto mode ends
                    st_nxt = st_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r  <= AGCO_WAIT;
            tmr_r <= '0;
        end else begin
            st_r  <= st_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // gain action gating and observe code
    logic                up_r;
    logic                up_nxt;
    logic                down_r;
    logic                down_nxt;
    logic [CODE_W-1:0]   code_r;
    logic [CODE_W-1:0]   code_nxt;
    logic                dwr_r;
    logic                dwr_nxt;
    logic                awr_r;
    logic                awr_nxt;
    logic [1:0]          chan_r;
    logic [1:0]          chan_nxt;
    logic [AUX_N-1:0]    dheld_r;
    logic [AUX_N-1:0]    dheld_nxt;
    logic [AUX_N-1:0]    aheld_r;
    logic [AUX_N-1:0]    aheld_nxt;
    logic                obs_ok;
    logic                allow_down;
    logic                allow_up;
    logic                wr;

    always_comb begin
        obs_ok     = cfg_i.obs_en && (cfg_i.variant != AGCO_FI_6);
        allow_down = 1'b0;
        allow_up   = 1'b0;
        code_nxt   = code_r;
        case (st_r)
            AGCO_WAIT: begin
                code_nxt   = CODE_WAIT;
                allow_down = sense_d.clip || sense_d.above_high;
                allow_up   = sense_d.below_low;
            end
            AGCO_BURST: begin
                code_nxt   = CODE_BURST;
                allow_down = sense_d.clip || sense_d.above_high;
                allow_up   = sense_d.below_low;
            end
            AGCO_PRE_NOHI: begin
                code_nxt   = CODE_NOHI;
                allow_down = sense_d.clip;
                allow_up   = sense_d.below_low;
            end
            AGCO_FS_LOCK: begin
                code_nxt   = CODE_LOCK;
            end
            AGCO_FS_DOWN: begin
                code_nxt   = CODE_DOWN;
                allow_down = sense_d.clip || sense_d.above_high;
            end
            default: begin
                code_nxt   = code_r;
                allow_down = sense_d.clip || sense_d.above_high;
                allow_up   = sense_d.below_low;
            end
        endcase
        if (auto_on) begin
            down_nxt = allow_down;
            up_nxt   = allow_up && !allow_down;
        end else begin
            down_nxt = (cfg_i.mode == AGCO_MODE_MANUAL) && man_down_i;
            up_nxt   = (cfg_i.mode == AGCO_MODE_MANUAL) && man_up_i && !man_down_i;
        end
        // a newly chosen target (first enable, other channel, other converter kind) gets the code at once
        wr        = obs_ok && ((code_nxt != code_r) || (chan_r != cfg_i.obs_chan)
                    || (cfg_i.obs_to_dac ? (dheld_r == '0) : (aheld_r == '0)));
        dwr_nxt   = wr && cfg_i.obs_to_dac;
        awr_nxt   = wr && !cfg_i.obs_to_dac;
        chan_nxt  = cfg_i.obs_chan;
        dheld_nxt = '0;
        aheld_nxt = '0;
        if (obs_ok) begin
            if (cfg_i.obs_to_dac) begin
                dheld_nxt[cfg_i.obs_chan] = 1'b1;
            end else begin
                aheld_nxt[cfg_i.obs_chan] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            up_r    <= 1'b0;
            down_r  <= 1'b0;
            code_r  <= CODE_WAIT;
            dwr_r   <= 1'b0;
            awr_r   <= 1'b0;
            chan_r  <= 2'h0;
            dheld_r <= '0;
            aheld_r <= '0;
        end else begin
            up_r    <= up_nxt;
            down_r  <= down_nxt;
            code_r  <= code_nxt;
            dwr_r   <= dwr_nxt;
            awr_r   <= awr_nxt;
            chan_r  <= chan_nxt;
            dheld_r <= dheld_nxt;
            aheld_r <= aheld_nxt;
        end
    end

    assign gain_up_o    = up_r;
    assign gain_down_o  = down_r;
    assign obs_code_o   = code_r;
    assign obs_dac_wr_o = dwr_r;
    assign obs_adc_wr_o = awr_r;
    assign obs_chan_o   = chan_r;
    assign dac_held_o   = dheld_r;
    assign adc_held_o   = aheld_r;
    assign state_o      = st_r;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_wait_code: assert property ((st_r == AGCO_WAIT) |=> (code_r == CODE_WAIT))
        else $error("wait state code not 000");
    chk_burst_code: assert property ((st_r == AGCO_BURST) |=> (code_r == CODE_BURST))
        else $error("burst state code not 100");
    chk_nohi_block: assert property ((st_r == AGCO_PRE_NOHI && auto_on && !sense_d.clip && sense_d.above_high)
        |=> !gain_down_o)
        else $error("above high acted in no-high state");
    chk_lock_freeze: assert property ((st_r == AGCO_FS_LOCK && auto_on) |=> (!gain_up_o && !gain_down_o
        && code_r == CODE_LOCK))
        else $error("gain changed in lock state");
    chk_down_only: assert property ((st_r == AGCO_FS_DOWN && auto_on) |=> (!gain_up_o && code_r == CODE_DOWN))
        else $error("gain raised in down-only state");
    chk_any_hold: assert property ((st_r == AGCO_FS_ANY) |=> $stable(code_r))
        else $error("code changed in any-action state");
    chk_fi6_off: assert property ((cfg_i.variant == AGCO_FI_6) |=> (!obs_dac_wr_o && !obs_adc_wr_o
        && dac_held_o == '0 && adc_held_o == '0))
        else $error("observe active in sixth variant");
    chk_held_dac: assert property ((obs_dac_wr_o) |-> dac_held_o[obs_chan_o])
        else $error("dac written without being held");
    chk_auto_rx: assert property ((!rx_mode_i && cfg_i.mode != AGCO_MODE_MANUAL) |=> (!gain_up_o && !gain_down_o))
        else $error("auto gain acted outside receive");
    chk_fs_delay: assert property ((st_r == AGCO_BURST || st_r == AGCO_PRE_NOHI) ##1
        (st_r == AGCO_FS_LOCK || st_r == AGCO_FS_DOWN || st_r == AGCO_FS_ANY)
        |-> $past(fsync_i, FSYNC_DELAY + 1))
        else $error("frame sync bypassed its delay");

    cov_burst: cover property ((st_r == AGCO_WAIT) ##1 (st_r == AGCO_BURST));
    cov_lock: cover property ((st_r == AGCO_BURST) ##1 (st_r == AGCO_FS_LOCK));
    cov_timeout: cover property ((st_r == AGCO_BURST) ##1 (st_r == AGCO_WAIT && auto_on));
    cov_dac_wr: cover property (obs_dac_wr_o && obs_code_o == CODE_DOWN);

endmodule // agco_observe

// >>> rtl/agco_pkg.sv
// shared types and constants for the gain control state observer
package agco_pkg;

    // core clock and symbol timing
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned SYM_RATE_HZ   = 9_600;
    localparam int unsigned UNIT_NUM      = 6;
    localparam int unsigned UNIT_DEN      = 5;
    localparam int unsigned UNIT_CYC      = (CLK_HZ * UNIT_NUM) / (UNIT_DEN * SYM_RATE_HZ);

    // sensing delays, in clock cycles
    localparam int unsigned SENSE_DLY     = 2;
    localparam int unsigned FS_DLY        = 8;
    // time allowed for frame sync after burst start, in timer units
    localparam int unsigned FS_WAIT_UNITS = 64;

    // observe code width and values
    localparam int unsigned CODE_W        = 10;
    localparam logic [CODE_W-1:0] CODE_WAIT  = 10'h000;
    localparam logic [CODE_W-1:0] CODE_BURST = 10'h100;
    localparam logic [CODE_W-1:0] CODE_NOHI  = 10'h200;
    localparam logic [CODE_W-1:0] CODE_LOCK  = 10'h300;
    localparam logic [CODE_W-1:0] CODE_DOWN  = 10'h380;

    // number of aux converters of each kind
    localparam int unsigned AUX_N         = 4;

    typedef enum logic [2:0] {
        AGCO_WAIT     = 3'b000,
        AGCO_BURST    = 3'b001,
        AGCO_PRE_NOHI = 3'b010,
        AGCO_FS_LOCK  = 3'b011,
        AGCO_FS_DOWN  = 3'b100,
        AGCO_FS_ANY   = 3'b101
    } agco_state_t;

    typedef enum logic [1:0] {
        AGCO_MODE_MANUAL = 2'b00,
        AGCO_MODE_FULL   = 2'b01,
        AGCO_MODE_LOCK   = 2'b10,
        AGCO_MODE_DOWN   = 2'b11
    } agco_mode_t;

    typedef enum logic [1:0] {
        AGCO_FI_1 = 2'b00,
        AGCO_FI_2 = 2'b01,
        AGCO_FI_4 = 2'b10,
        AGCO_FI_6 = 2'b11
    } agco_variant_t;

    // signal conditions seen by the gain control
    typedef struct packed {
        logic clip;
        logic above_high;
        logic below_low;
    } agco_sense_t;

    // observe and gain control configuration
    typedef struct packed {
        logic          obs_en;
        logic          obs_to_dac;
        logic [1:0]    obs_chan;
        agco_mode_t    mode;
        logic          no_high;
        agco_variant_t variant;
    } agco_cfg_t;

endpackage

// >>> rtl/agco_unit_tick.sv
// timer unit tick generator, one pulse per six fifths of a symbol
`timescale 1ns/1ps
module agco_unit_tick
    import agco_pkg::*;
#(
    parameter int unsigned UNIT_CYCLES = UNIT_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic clr_i,
    // tick out
    output logic      tick_o
);

    localparam int unsigned CW = $clog2(UNIT_CYCLES + 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;

    always_comb begin
        cnt_nxt  = cnt_r + 1'b1;
        tick_nxt = 1'b0;
        if (clr_i) begin
            cnt_nxt = '0;
        end else if (cnt_r == CW'(UNIT_CYCLES - 1)) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_o = tick_r;

endmodule // agco_unit_tick

// >>> sim/test_agc_state_observe.sv
// self-checking bench for the gain control state observer
`timescale 1ns/1ps
module test_agc_state_observe;
    import agco_pkg::*;

    localparam int unsigned UNITS = 4;
    localparam int unsigned WAITU = 16;

    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    agco_cfg_t         cfg_i;
    logic              rx_mode_i;
    agco_sense_t       sense_i;
    logic              burst_start_i;
    logic              fsync_i;
    logic              man_up_i;
    logic              man_down_i;
    logic              gain_up_o;
    logic              gain_down_o;
    logic [CODE_W-1:0] obs_code_o;
    logic              obs_dac_wr_o;
    logic              obs_adc_wr_o;
    logic [1:0]        obs_chan_o;
    logic [AUX_N-1:0]  dac_held_o;
    logic [AUX_N-1:0]  adc_held_o;
    agco_state_t       state_o;
    int                fail_count = 0;
    int                n_checks = 0;

    agco_observe #(.UNIT_CYCLES(UNITS), .FS_WAIT(WAITU)) u_agco_observe (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i), .rx_mode_i(rx_mode_i), .sense_i(sense_i),
        .burst_start_i(burst_start_i), .fsync_i(fsync_i), .man_up_i(man_up_i), .man_down_i(man_down_i),
        .gain_up_o(gain_up_o), .gain_down_o(gain_down_o), .obs_code_o(obs_code_o),
        .obs_dac_wr_o(obs_dac_wr_o), .obs_adc_wr_o(obs_adc_wr_o), .obs_chan_o(obs_chan_o),
        .dac_held_o(dac_held_o), .adc_held_o(adc_held_o), .state_o(state_o)
    );

    always #20 clk_i = ~clk_i;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wait_state(input string what, input agco_state_t s, input int max);
        for (int i = 0; i < max && state_o !== s; i++) @(negedge clk_i);
        check(what, state_o, s);
    endtask

    // one-cycle sense sample, then count gain pulses that follow
    task automatic probe(input string what, input agco_sense_t s, input logic [31:0] eu, input logic [31:0] ed);
        logic [31:0] nu;
        logic [31:0] nd;
        int          first;
        nu = '0;
        nd = '0;
        first = -1;
        @(posedge clk_i) sense_i <= s;
        @(posedge clk_i) sense_i <= '0;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_i);
            if (first < 0 && (gain_up_o === 1'b1 || gain_down_o === 1'b1)) begin
                first = i;
            end
            nu = nu + gain_up_o;
            nd = nd + gain_down_o;
        end
        check({what, " up"}, nu, eu);
        check({what, " down"}, nd, ed);
        if (eu + ed != 0) begin
            check({what, " lag"}, first, SENSE_DLY);
        end
    endtask

    // burst start, then count observe writes of each kind
    task automatic enter_burst(input logic [31:0] edac, input logic [31:0] eadc);
        logic [31:0] nw_dac;
        logic [31:0] nw_adc;
        nw_dac = '0;
        nw_adc = '0;
        @(posedge clk_i) burst_start_i <= 1'b1;
        @(posedge clk_i) burst_start_i <= 1'b0;
        repeat (5) begin
            @(negedge clk_i);
            nw_dac = nw_dac + obs_dac_wr_o;
            nw_adc = nw_adc + obs_adc_wr_o;
        end
        check("dac writes", nw_dac, edac);
        check("adc writes", nw_adc, eadc);
    endtask

    task automatic to_idle();
        @(posedge clk_i) rx_mode_i <= 1'b0;
        @(posedge clk_i) rx_mode_i <= 1'b1;
        @(negedge clk_i);
        wait_state("idle state", AGCO_WAIT, 4);
        @(negedge clk_i);
        check("idle code", obs_code_o, CODE_WAIT);
    endtask

    task automatic t_reset();
        @(negedge clk_i);
        check("reset state", state_o, AGCO_WAIT);
        check("reset code", obs_code_o, CODE_WAIT);
        check("reset held", {dac_held_o, adc_held_o}, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_wait_probe();
        probe("wait clip", 3'b100, 0, 1);
        probe("wait high", 3'b010, 0, 1);
        probe("wait low", 3'b001, 1, 0);
        $display("test wait done");
    endtask

    task automatic t_burst_dac();
        @(posedge clk_i) cfg_i <= '{1'b1, 1'b1, 2'd2, AGCO_MODE_FULL, 1'b0, AGCO_FI_1};
        enter_burst(1, 0);
        check("burst state", state_o, AGCO_BURST);
        check("burst code", obs_code_o, CODE_BURST);
        check("write chan", obs_chan_o, 2'd2);
        check("dac held", {dac_held_o, adc_held_o}, 8'h40);
        probe("burst low", 3'b001, 1, 0);
        probe("burst high", 3'b010, 0, 1);
        to_idle();
        @(posedge clk_i) cfg_i.obs_en <= 1'b0;
        repeat (3) @(negedge clk_i);
        check("held release", {dac_held_o, adc_held_o}, 8'h00);
        $display("test burst dac done");
    endtask

    task automatic t_nohi();
        @(posedge clk_i) cfg_i <= '{1'b1, 1'b0, 2'd1, AGCO_MODE_FULL, 1'b1, AGCO_FI_2};
        enter_burst(0, 2);
        wait_state("nohi state", AGCO_PRE_NOHI, 4);
        @(negedge clk_i);
        check("nohi code", obs_code_o, CODE_NOHI);
        check("adc held", {dac_held_o, adc_held_o}, 8'h02);
        probe("nohi high", 3'b010, 0, 0);
        probe("nohi clip", 3'b100, 0, 1);
        probe("nohi low", 3'b001, 1, 0);
        to_idle();
        $display("test nohi done");
    endtask

    task automatic t_fsync();
        agco_mode_t  md [3] = '{AGCO_MODE_LOCK, AGCO_MODE_DOWN, AGCO_MODE_FULL};
        agco_state_t st [3] = '{AGCO_FS_LOCK, AGCO_FS_DOWN, AGCO_FS_ANY};
        logic [CODE_W-1:0] cd [3] = '{CODE_LOCK, CODE_DOWN, CODE_BURST};
        logic [2:0]  dn [3] = '{3'b000, 3'b110, 3'b110};
        logic        up [3] = '{1'b0, 1'b0, 1'b1};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i) cfg_i <= '{1'b1, 1'b1, 2'd0, md[k], 1'b0, AGCO_FI_4};
            enter_burst(1, 0);
            @(posedge clk_i) fsync_i <= 1'b1;
            @(posedge clk_i) fsync_i <= 1'b0;
            repeat (3) @(negedge clk_i);
            check("fsync lag", state_o, AGCO_BURST);
            wait_state("fsync state", st[k], 10);
            @(negedge clk_i);
            check("fsync code", obs_code_o, cd[k]);
            probe("fs clip", 3'b100, 0, dn[k][2]);
            probe("fs high", 3'b010, 0, dn[k][1]);
            probe("fs low", 3'b001, up[k], 0);
            to_idle();
        end
        $display("test fsync done");
    endtask

    task automatic t_variant6();
        @(posedge clk_i) cfg_i <= '{1'b1, 1'b1, 2'd3, AGCO_MODE_FULL, 1'b0, AGCO_FI_6};
        enter_burst(0, 0);
        check("v6 held", {dac_held_o, adc_held_o}, 8'h00);
        to_idle();
        $display("test variant6 done");
    endtask

    task automatic t_manual();
        @(posedge clk_i) rx_mode_i <= 1'b0;
        probe("no rx auto", 3'b100, 0, 0);
        @(posedge clk_i) cfg_i.mode <= AGCO_MODE_MANUAL;
        @(posedge clk_i) man_down_i <= 1'b1;
        @(posedge clk_i) man_down_i <= 1'b0;
        @(negedge clk_i);
        check("man down", gain_down_o, 1'b1);
        @(posedge clk_i) man_up_i <= 1'b1;
        @(posedge clk_i) man_up_i <= 1'b0;
        @(negedge clk_i);
        check("man up", gain_up_o, 1'b1);
        @(posedge clk_i) cfg_i.mode <= AGCO_MODE_FULL;
        rx_mode_i <= 1'b1;
        $display("test manual done");
    endtask

    task automatic t_timeout();
        enter_burst(0, 0);
        repeat (40) @(negedge clk_i);
        check("timer running", state_o, AGCO_BURST);
        wait_state("timeout state", AGCO_WAIT, 40);
        @(negedge clk_i);
        check("timeout code", obs_code_o, CODE_WAIT);
        $display("test timeout done");
    endtask

    initial begin
        cfg_i = '{1'b0, 1'b0, 2'd0, AGCO_MODE_FULL, 1'b0, AGCO_FI_1};
        rx_mode_i = 1'b1;
        sense_i = '0;
        burst_start_i = 1'b0;
        fsync_i = 1'b0;
        man_up_i = 1'b0;
        man_down_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_wait_probe();
        t_burst_dac();
        t_nohi();
        t_fsync();
        t_variant6();
        t_manual();
        t_timeout();
        close_out();
    end

    initial begin
        repeat (3000) @(posedge clk_i);
        fail_count++;
        close_out();
    end

endmodule // test_agc_state_observe
